// ==== include/rpc_pkg.sv ====
// Purpose: shared constants for the rtc domain power control block
// Assumes: 16-bit register port, word addresses as printed
// Notes: status and mask registers sit at locally chosen offsets
package rpc_pkg;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 16;
  localparam logic [15:0] POWER_CONTROL_OFS = 16'h1930;
  localparam logic [15:0] EVENT_FLAGS_OFS = 16'h1920;
  localparam logic [15:0] EVENT_MASK_OFS = 16'h1922;
  localparam logic [15:0] WAKE_ENABLE_OFS = 16'h1924;
  localparam int unsigned CLK_OUT_EN_BIT = 0;
  localparam int unsigned REG_SHDN_BIT = 1;
  localparam int unsigned REF_SHDN_BIT = 2;
  localparam int unsigned WAKE_DIR_BIT = 3;
  localparam int unsigned WAKE_LEVEL_BIT = 4;
  localparam int unsigned PERIODIC_W = 5;
  localparam int unsigned EXT_FLAG_BIT = 5;
  localparam int unsigned ALARM_FLAG_BIT = 15;
  localparam logic [4:0] POWER_CONTROL_RST = 5'h10;
  localparam logic [15:0] FLAGS_MASK = 16'h803f;
  localparam logic [15:0] WAKE_ENABLE_RST = 16'h0000;
  localparam logic [15:0] EVENT_MASK_RST = 16'h0000;
  localparam int unsigned CLK_HZ = 250000000;
  localparam int unsigned SETTLE_MS = 100;
  localparam longint unsigned SETTLE_CYC = longint'(CLK_HZ) / 1000 * SETTLE_MS;
endpackage

// ==== core/rpc_sticky_flag.sv ====
// Purpose: one sticky event flag, write one to clear
// Assumes: event and clear are single-clock pulses or levels
// Notes: a set in the clear cycle wins
`timescale 1ns/1ns
module rpc_sticky_flag (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic set_i,
  input wire logic clr_i,
  output logic flag_o
);
  logic next_flag;

  always_comb begin
    next_flag = set_i | (flag_o & ~clr_i);
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      flag_o <= 1'b0;
    end else begin
      flag_o <= next_flag;
    end
  end
endmodule

// ==== core/rpc_power_ctrl.sv ====
// Purpose: rtc domain power control register, wake pin and shutdown sequencing
// Assumes: register port strobes one cycle long, read data one cycle later
// Notes: analog enables are active-high power requests to the regulators
// Operation
// - output mode drives wake low when level zero
// - direction bit selects wake input or output
// - wake input high asserts; output open drain
// - reference shutdown powers off regulators, comparator, bandgap
// - reference shutdown ends only on enabled wake; pin high in input mode ends it regardless of wake_en
// - regulator shutdown keeps bandgap on, others off
// - regulator shutdown ends only on enabled wake or the reference shutdown bit; pin high in input mode ends it regardless of wake_en
// - alarm sets flag bit 15, write one clears
// - wake pin sets flag bit 5, write one clears
`timescale 1ns/1ns
module rpc_power_ctrl #(
  parameter int unsigned PERIODIC_N = rpc_pkg::PERIODIC_W
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic [rpc_pkg::ADDR_W-1:0] addr_i,
  input wire logic [rpc_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [rpc_pkg::DATA_W-1:0] rdata_o,
  input wire logic wake_pin_i,
  output logic wake_pin_o,
  output logic wake_pin_oe_o,
  input wire logic rtc_clk_i,
  output logic rtc_clock_out_pin_o,
  input wire logic alarm_i,
  input wire logic [PERIODIC_N-1:0] periodic_i,
  output logic regulator_en_o,
  output logic reset_cmp_en_o,
  output logic bandgap_en_o,
  output logic irq_o
);
  import rpc_pkg::*;

  // the flag layout is fixed, so only the documented event count fits
  if (PERIODIC_N != PERIODIC_W) begin : g_bad_cfg
    $error("periodic event count must match the flag layout");
  end

  typedef enum logic [2:0] {
    RPC_RUN = 3'b001,
    RPC_REG_OFF = 3'b010,
    RPC_REF_OFF = 3'b100
  } rpc_state_e;

  rpc_state_e state, next_state;
  logic [4:0] ctrl, next_ctrl;
  logic [15:0] mask, next_mask;
  logic [15:0] wake_en, next_wake_en;
  logic [15:0] flags;
  logic [15:0] set_vec, clr_vec;
  logic [15:0] next_rdata;
  logic wake_prev;
  logic wake_rise, wake_event;
  logic next_pin_oe, next_reg_en, next_bg_en, next_irq;
  logic ctrl_wr, flag_wr, mask_wr, wen_wr;

  assign ctrl_wr = wr_i && addr_i == POWER_CONTROL_OFS;
  assign flag_wr = wr_i && addr_i == EVENT_FLAGS_OFS;
  assign mask_wr = wr_i && addr_i == EVENT_MASK_OFS;
  assign wen_wr = wr_i && addr_i == WAKE_ENABLE_OFS;

  // input mode only: our own low drive must not look like an event
  assign wake_rise = wake_pin_i & ~wake_prev & ~ctrl[WAKE_DIR_BIT];

  always_comb begin
    set_vec = 16'h0000;
    set_vec[ALARM_FLAG_BIT] = alarm_i;
    set_vec[EXT_FLAG_BIT] = wake_rise;
    set_vec[PERIODIC_W-1:0] = periodic_i;
    clr_vec = flag_wr ? (wdata_i & FLAGS_MASK) : 16'h0000;
  end

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_flag
      if (FLAGS_MASK[gi]) begin : g_used
        rpc_sticky_flag u_flag (
          .sys_clk_i(sys_clk_i),
          .sys_rst_i(sys_rst_i),
          .set_i(set_vec[gi]),
          .clr_i(clr_vec[gi]),
          .flag_o(flags[gi])
        );
      end else begin : g_zero
        assign flags[gi] = 1'b0;
      end
    end
  endgenerate

  // alarm and periodic wake only if enabled; pin high wakes in input mode
  assign wake_event = (wake_pin_i & ~ctrl[WAKE_DIR_BIT]) | (|(set_vec & wake_en));

  always_comb begin
    next_ctrl = ctrl;
    next_mask = mask;
    next_wake_en = wake_en;
    next_state = state;
    if (ctrl_wr) begin
      next_ctrl = wdata_i[4:0];
    end
    if (mask_wr) begin
      next_mask = wdata_i & FLAGS_MASK;
    end
    if (wen_wr) begin
      next_wake_en = wdata_i & FLAGS_MASK;
    end
    case (state)
      RPC_RUN: begin
        if (ctrl[REF_SHDN_BIT]) begin
          next_state = RPC_REF_OFF;
        end else if (ctrl[REG_SHDN_BIT]) begin
          next_state = RPC_REG_OFF;
        end
      end
      RPC_REG_OFF: begin
        if (ctrl[REF_SHDN_BIT]) begin
          next_state = RPC_REF_OFF;
        end else if (wake_event) begin
          next_state = RPC_RUN;
          next_ctrl[REG_SHDN_BIT] = 1'b0;
        end
      end
      RPC_REF_OFF: begin
        if (wake_event) begin
          next_state = RPC_RUN;
          next_ctrl[REF_SHDN_BIT] = 1'b0;
          next_ctrl[REG_SHDN_BIT] = 1'b0;
        end
      end
      default: next_state = RPC_RUN;
    endcase
    // is software's duty; shutdown is honoured regardless
    next_reg_en = (next_state == RPC_RUN);
    next_bg_en = (next_state != RPC_REF_OFF);
    next_pin_oe = next_ctrl[WAKE_DIR_BIT] & ~next_ctrl[WAKE_LEVEL_BIT];
    next_irq = |(flags & mask & ~clr_vec) | |(set_vec & next_mask);
  end

  always_comb begin
    next_rdata = 16'h0000;
    if (rd_i) begin
      case (addr_i)
        POWER_CONTROL_OFS: next_rdata = {11'h000, ctrl};
        EVENT_FLAGS_OFS: next_rdata = flags;
        EVENT_MASK_OFS: next_rdata = mask;
        WAKE_ENABLE_OFS: next_rdata = wake_en;
        default: next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state <= RPC_RUN;
      ctrl <= POWER_CONTROL_RST;
      mask <= EVENT_MASK_RST;
      wake_en <= WAKE_ENABLE_RST;
      wake_prev <= 1'b0;
      rdata_o <= 16'h0000;
      wake_pin_oe_o <= 1'b0;
      regulator_en_o <= 1'b1;
      reset_cmp_en_o <= 1'b1;
      bandgap_en_o <= 1'b1;
      irq_o <= 1'b0;
      rtc_clock_out_pin_o <= 1'b0;
      wake_pin_o <= 1'b0;
    end else begin
      // open drain: the value is always low, only the enable moves
      wake_pin_o <= 1'b0;
      state <= next_state;
      ctrl <= next_ctrl;
      mask <= next_mask;
      wake_en <= next_wake_en;
      wake_prev <= wake_pin_i;
      rdata_o <= next_rdata;
      wake_pin_oe_o <= next_pin_oe;
      regulator_en_o <= next_reg_en;
      reset_cmp_en_o <= next_reg_en;
      bandgap_en_o <= next_bg_en;
      irq_o <= next_irq;
      // clock sampled, not gated: keeps the pin glitch free
      rtc_clock_out_pin_o <= rtc_clk_i & ctrl[CLK_OUT_EN_BIT];
    end
  end

  // checks
  ref_off_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    state == RPC_REF_OFF |-> !bandgap_en_o && !regulator_en_o)
    else $error("reference shutdown left supplies on");
  reg_off_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    state == RPC_REG_OFF |-> bandgap_en_o && !reset_cmp_en_o)
    else $error("regulator shutdown state wrong");
  ref_hold_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    state == RPC_REF_OFF && !wake_event |=> state == RPC_REF_OFF)
    else $error("left reference shutdown without wake");
  reg_hold_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    state == RPC_REG_OFF && !wake_event && !ctrl[REF_SHDN_BIT] |=> state == RPC_REG_OFF)
    else $error("left regulator shutdown without wake");
  wake_drive_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    ctrl_wr ##1 !ctrl_wr |=> wake_pin_oe_o == ($past(ctrl[WAKE_DIR_BIT], 1) && !$past(ctrl[WAKE_LEVEL_BIT], 1)))
    else $error("wake pin drive disagrees with control");
  wake_dir_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    !ctrl[WAKE_DIR_BIT] && !ctrl_wr |=> !wake_pin_oe_o)
    else $error("wake pin driven in input mode");
  ext_flag_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    wake_rise |=> flags[EXT_FLAG_BIT])
    else $error("external event flag not set");
  alarm_flag_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    alarm_i |=> flags[ALARM_FLAG_BIT])
    else $error("alarm flag not set");
  rsvd_zero_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    rd_i && addr_i == POWER_CONTROL_OFS |=> rdata_o[15:5] == 11'h000)
    else $error("reserved bits not zero");
  clk_off_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    !ctrl[CLK_OUT_EN_BIT] |=> !rtc_clock_out_pin_o)
    else $error("clock out active while disabled");

  // wake pin drive
  wake_low_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    !wake_pin_o)
    else $error("wake pin value not low");
  oe_match_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    wake_pin_oe_o == (ctrl[WAKE_DIR_BIT] && !ctrl[WAKE_LEVEL_BIT]))
    else $error("wake enable disagrees with control");
  oe_input_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    !ctrl[WAKE_DIR_BIT] |-> !wake_pin_oe_o)
    else $error("wake pin driven as input");
  oe_release_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    ctrl[WAKE_LEVEL_BIT] |-> !wake_pin_oe_o)
    else $error("wake pin not released");

  // wake pin sensing
  no_rise_out_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    ctrl[WAKE_DIR_BIT] |-> !wake_rise)
    else $error("wake event seen in output mode");
  rise_edge_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    wake_rise |-> wake_pin_i && !wake_prev)
    else $error("wake event without rising pin");

  // supply enables
  cmp_follow_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    reset_cmp_en_o == regulator_en_o)
    else $error("comparator enable split from regulators");
  run_on_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    state == RPC_RUN |-> regulator_en_o && bandgap_en_o)
    else $error("supplies off while running");
  ref_enter_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    state == RPC_RUN && ctrl[REF_SHDN_BIT] |=> state == RPC_REF_OFF)
    else $error("reference shutdown not entered");
  reg_enter_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    state == RPC_RUN && ctrl[REG_SHDN_BIT] && !ctrl[REF_SHDN_BIT] |=> state == RPC_REG_OFF)
    else $error("regulator shutdown not entered");

  // wake from shutdown
  ref_wake_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    state == RPC_REF_OFF && wake_event |=> state == RPC_RUN && bandgap_en_o)
    else $error("no return from reference shutdown");
  reg_wake_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    state == RPC_REG_OFF && wake_event && !ctrl[REF_SHDN_BIT] |=> regulator_en_o)
    else $error("no return from regulator shutdown");
  ref_bits_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    state == RPC_REF_OFF && wake_event |=> !ctrl[REF_SHDN_BIT] && !ctrl[REG_SHDN_BIT])
    else $error("shutdown bits kept after wake");
  reg_bits_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    state == RPC_REG_OFF && wake_event && !ctrl[REF_SHDN_BIT] |=> !ctrl[REG_SHDN_BIT])
    else $error("regulator bit kept after wake");

  // clock out and register port
  clk_on_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    ctrl[CLK_OUT_EN_BIT] |=> rtc_clock_out_pin_o == $past(rtc_clk_i))
    else $error("clock out not following rtc clock");
  ctrl_write_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    ctrl_wr && state == RPC_RUN |=> ctrl == $past(wdata_i[4:0]))
    else $error("control write lost");
  ctrl_read_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    rd_i && addr_i == POWER_CONTROL_OFS |=> rdata_o[4:0] == $past(ctrl))
    else $error("control read wrong");

  // event flags: a set in the clear cycle wins
  alarm_clr_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    flag_wr && wdata_i[ALARM_FLAG_BIT] && !alarm_i |=> !flags[ALARM_FLAG_BIT])
    else $error("alarm flag not cleared");
  alarm_hold_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    flags[ALARM_FLAG_BIT] && !(flag_wr && wdata_i[ALARM_FLAG_BIT]) |=> flags[ALARM_FLAG_BIT])
    else $error("alarm flag dropped");
  ext_clr_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    flag_wr && wdata_i[EXT_FLAG_BIT] && !wake_rise |=> !flags[EXT_FLAG_BIT])
    else $error("external flag not cleared");
  ext_hold_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    flags[EXT_FLAG_BIT] && !(flag_wr && wdata_i[EXT_FLAG_BIT]) |=> flags[EXT_FLAG_BIT])
    else $error("external flag dropped");
  flag_rsvd_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    flags[14:6] == 9'h000)
    else $error("reserved flag bits set");
endmodule

// ==== bench/rpc_wake_partner.sv ====
// Purpose: board side of the wake pin, with its pull-up
// Assumes: ext_level_i high means driven high or released to the pull-up
// Notes: any low driver wins, like a real open-drain wire
`timescale 1ns/1ns
module rpc_wake_partner (
  input wire logic ext_level_i,
  input wire logic dev_oe_i,
  input wire logic dev_out_i,
  output wire logic wake_o
);
  assign wake_o = (dev_oe_i && !dev_out_i) ? 1'b0 : ext_level_i;
  // supplies here are ideal, so no settle wait is needed
  // the bench never models bypassed regulators
endmodule

// ==== bench/rtc_domain_power_control_tb_top.sv ====
// Purpose: self-checking bench for the rtc power control block
// Assumes: wake sources idle unless a scenario raises them
// Notes: random control writes, then wake and flag corner cases
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin n_errors++; \
  $display("ERROR %s exp %h got %h", nm, ex, got); end end
module rtc_domain_power_control_tb_top;
  import rpc_pkg::*;
  logic sys_clk_i = 0, sys_rst_i = 1, wr_i = 0, rd_i = 0, rtc_clk_i = 0, alarm_i = 0;
  logic rtc_prev = 0, ext_level = 0;
  logic [15:0] addr_i = 0, wdata_i = 0, rd_val, d, rdata_o;
  logic [4:0] periodic_i = 0;
  logic wake_wire, wake_pin_o, wake_pin_oe_o, rtc_clock_out_pin_o, irq_o;
  logic regulator_en_o, reset_cmp_en_o, bandgap_en_o;
  integer n_errors = 0, num_checks = 0, seed = 24681, i;
  int pwr = 0;
  always #2 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) begin
    rtc_prev <= rtc_clk_i;
    rtc_clk_i <= $random(seed);
  end
  rpc_power_ctrl rpc_power_ctrl_inst (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .wake_pin_i(wake_wire), .wake_pin_o(wake_pin_o), .wake_pin_oe_o(wake_pin_oe_o),
    .rtc_clk_i(rtc_clk_i), .rtc_clock_out_pin_o(rtc_clock_out_pin_o), .alarm_i(alarm_i),
    .periodic_i(periodic_i), .regulator_en_o(regulator_en_o),
    .reset_cmp_en_o(reset_cmp_en_o), .bandgap_en_o(bandgap_en_o), .irq_o(irq_o));
  rpc_wake_partner rpc_wake_partner_inst (.ext_level_i(ext_level), .dev_oe_i(wake_pin_oe_o),
    .dev_out_i(wake_pin_o), .wake_o(wake_wire));
  function automatic logic [15:0] flag_of(input int k);
    return (k < 5) ? (16'h0001 << k) : 16'h8000;
  endfunction
  // power state model: 0 run, 1 regulators off, 2 reference off; only a wake leaves off
  function automatic int next_pwr(input int p, input logic [15:0] v);
    if (p == 0) return v[2] ? 2 : (v[1] ? 1 : 0);
    return (p == 1 && v[2]) ? 2 : p;
  endfunction
  task automatic wr(input logic [15:0] a, input logic [15:0] v);
    @(posedge sys_clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= v;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge sys_clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1 rd_val = rdata_o;
  endtask
  task automatic ev(input int k);
    @(posedge sys_clk_i);
    if (k < 5) periodic_i[k] <= 1'b1;
    else alarm_i <= 1'b1;
    @(posedge sys_clk_i);
    periodic_i <= 5'h00;
    alarm_i <= 1'b0;
  endtask
  // bounded wait: a missing wake shows up as a compare failure
  task automatic wait_wake;
    for (int j = 0; j < 8 && regulator_en_o !== 1'b1; j++) begin
      @(posedge sys_clk_i);
      #1;
    end
  endtask
  task automatic settle;
    repeat (3) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    #40000;
    n_errors++;
    print_verdict();
  end
  initial begin
    repeat (16) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    rd(POWER_CONTROL_OFS);
    `CHK("ctrl reset", 16'h0010, rd_val)
    `CHK("enables reset", 3'b111, {regulator_en_o, reset_cmp_en_o, bandgap_en_o})
    rd(16'h1000);
    `CHK("unmapped", 16'h0000, rd_val)
    for (i = 0; i < 40; i++) begin
      d = $random(seed);
      wr(POWER_CONTROL_OFS, d);
      pwr = next_pwr(pwr, d);
      rd(POWER_CONTROL_OFS);
      `CHK("ctrl", {11'h000, d[4:0]}, rd_val)
      `CHK("wake oe", d[3] & ~d[4], wake_pin_oe_o)
      `CHK("enables", {{2{pwr == 0}}, pwr != 2}, {regulator_en_o, reset_cmp_en_o, bandgap_en_o})
      `CHK("clk out", rtc_prev & d[0], rtc_clock_out_pin_o)
    end
    wr(POWER_CONTROL_OFS, 16'h0010);
    ext_level <= 1'b1;
    settle();
    `CHK("loop wake", 3'b111, {regulator_en_o, reset_cmp_en_o, bandgap_en_o})
    ext_level <= 1'b0;
    wr(EVENT_FLAGS_OFS, 16'h0020);
    wr(POWER_CONTROL_OFS, 16'h0012);
    settle();
    `CHK("reg shdn", 3'b001, {regulator_en_o, reset_cmp_en_o, bandgap_en_o})
    ext_level <= 1'b1;
    wait_wake();
    `CHK("pin wake", 3'b111, {regulator_en_o, reset_cmp_en_o, bandgap_en_o})
    rd(EVENT_FLAGS_OFS);
    `CHK("ext flag", 16'h0020, rd_val)
    wr(EVENT_FLAGS_OFS, 16'h0020);
    ext_level <= 1'b0;
    rd(EVENT_FLAGS_OFS);
    `CHK("ext clear", 16'h0000, rd_val)
    wr(POWER_CONTROL_OFS, 16'h000c);
    ext_level <= 1'b1;
    ev(5);
    settle();
    `CHK("driven low", 1'b0, wake_wire)
    `CHK("no wake", 3'b000, {regulator_en_o, reset_cmp_en_o, bandgap_en_o})
    `CHK("irq masked", 1'b0, irq_o)
    wr(EVENT_MASK_OFS, 16'h8000);
    settle();
    `CHK("irq on", 1'b1, irq_o)
    wr(EVENT_FLAGS_OFS, 16'h8000);
    settle();
    `CHK("irq off", 1'b0, irq_o)
    ext_level <= 1'b0;
    for (i = 0; i < 6; i++) begin
      wr(POWER_CONTROL_OFS, 16'h0014);
      wr(WAKE_ENABLE_OFS, flag_of(i));
      ev(i);
      wait_wake();
      `CHK("src wake", 3'b111, {regulator_en_o, reset_cmp_en_o, bandgap_en_o})
      rd(EVENT_FLAGS_OFS);
      `CHK("src flag", flag_of(i), rd_val)
      wr(EVENT_FLAGS_OFS, flag_of(i));
    end
    print_verdict();
  end
endmodule
